/* File: hdl/flash_cmd_pkg.sv */
// Constants and types shared by the serial flash command decoder
package flash_cmd_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] FACTORY_SPEEDUP_CMD = 8'h41;
  localparam logic [7:0] THREE_BYTE_ID_CMD = 8'h9F;
  localparam logic [7:0] LEGACY_SIGNATURE_CMD = 8'hAB;
  localparam logic [7:0] MAKER_DEVICE_ID_CMD = 8'h90;
  localparam logic [7:0] QUAD_ID_CMD = 8'hAF;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] RESET_MEMORY_CMD = 8'h99;
  localparam logic [7:0] SUSPEND_CMD_A = 8'h75;
  localparam logic [7:0] SUSPEND_CMD_B = 8'hB0;
  localparam logic [7:0] SMALL_UNIT_WIPE_CMD = 8'h20;
  localparam logic [7:0] HALF_BLOCK_WIPE_CMD = 8'h52;
  localparam logic [7:0] BLOCK_WIPE_CMD = 8'hD8;
  localparam logic [7:0] DEVICE_WIPE_CMD_A = 8'h60;
  localparam logic [7:0] DEVICE_WIPE_CMD_B = 8'hC7;

  // ----------------------------------------------------------------
  // Bit counts, ID byte index, output enables and idle pin levels
  // ----------------------------------------------------------------
  localparam logic [4:0] OPCODE_BITS = 5'd8;
  localparam logic [4:0] PREAMBLE_BITS = 5'd24;
  localparam logic [4:0] SINGLE_STEP = 5'd1;
  localparam logic [4:0] QUAD_STEP = 5'd4;
  localparam logic [1:0] ID_BYTES_LAST = 2'd2;
  localparam logic [3:0] SPI_OUT_ENABLE = 4'h2;
  localparam logic [3:0] QPI_OUT_ENABLE = 4'hF;
  localparam logic [6:0] PINS_IDLE = 7'h6F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hw_reset_n;
    logic cs_n;
    logic sclk;
    logic [3:0] sio;
  } link_pins_type;

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_PREAMBLE,
    ST_DATA,
    ST_HOLD
  } frame_state_type;

  typedef enum logic [2:0] {
    RD_NONE,
    RD_ID3,
    RD_SIG,
    RD_PAIR,
    RD_QID,
    RD_STATUS
  } read_kind_type;

endpackage : flash_cmd_pkg

/* File: hdl/flash_pin_sync.sv */
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module flash_pin_sync #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] IDLE_VALUE = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Pins
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_check
    $error("flash_pin_sync needs a width of at least one");
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= IDLE_VALUE;
      pins_o <= IDLE_VALUE;
    end
    else
    begin
      meta_q <= pins_i;
      pins_o <= meta_q;
    end
  end

endmodule : flash_pin_sync

/* File: hdl/flash_out_shift.sv */
// Output byte shifter, one or four lanes per falling clock
`timescale 1ns/1ps
module flash_out_shift (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic clear_i,
  input wire logic step_i,
  input wire logic quad_i,
  input wire logic [7:0] byte_i,
  // Result
  output logic [3:0] lanes_o,
  output logic empty_o
);

  logic [7:0] sr_q;
  logic [3:0] cnt_q;

  assign empty_o = (cnt_q == 4'h0);

  always_ff @(posedge clk_i)
  begin
    if (reset_i || clear_i)
    begin
      sr_q <= 8'h00;
      cnt_q <= 4'h0;
      lanes_o <= 4'h0;
    end
    else if (step_i)
    begin
      if (empty_o)
      begin
        lanes_o <= quad_i ? byte_i[7:4] : {2'b00, byte_i[7], 1'b0};
        sr_q <= quad_i ? {byte_i[3:0], 4'h0} : {byte_i[6:0], 1'b0};
        cnt_q <= quad_i ? 4'h4 : 4'h7;
      end
      else
      begin
        lanes_o <= quad_i ? sr_q[7:4] : {2'b00, sr_q[7], 1'b0};
        sr_q <= quad_i ? {sr_q[3:0], 4'h0} : {sr_q[6:0], 1'b0};
        cnt_q <= quad_i ? cnt_q - 4'h4 : cnt_q - 4'h1;
      end
    end
  end

endmodule : flash_out_shift

/* File: hdl/flash_cmd_core.sv */
// Serial flash command decoder: latch, factory mode, ID and status reads
`timescale 1ns/1ps
// Behaviour
// [R1] Memory reset acts only when reset-arm was the command just before it.
// [R2] Host keeps to the defined opcodes; unknown ones are forwarded only.
// [R3] Latch-set command sets the write enable latch.
// [R4] Host sends latch-set before any content-altering command.
// [R5] Opcode is 8 clocks single-lane, 2 clocks quad; upper lines unused.
// [R6] Latch-clear command clears the write enable latch.
// [R7] Latch clears on reset, reset pin, latch-clear, soft reset, op completion.
// [R8] Host sends latch-set, factory speed-up, then one program or erase.
// [R9] Suspend is refused while factory speed-up mode is active.
// [R10] Factory mode clears on reset, reset pin, write/erase done, soft reset.
// [R11] Three-byte ID read, single-lane only: maker then two device bytes.
// [R12] Three-byte ID read is not decoded while an operation is busy.
// [R13] Chip select high after an ID read returns the device to standby.
// [R14] Legacy signature repeats while clocks continue after 24 skipped bits.
// [R15] Maker/device ID: two dummy bytes, address byte, MSB first on falls.
// [R16] Address bit zero picks maker or device first; output alternates.
// [R17] Quad ID read streams maker, type, density right after the opcode.
// [R18] Status read is accepted at any time, even while busy.
// [R19] Host polls write-in-progress before new commands while busy.
// [R20] Program and erase commands are dropped unless the latch is set.
// [R21] Write-in-progress reads one while an operation is running.
// [R22] A partial opcode cut short by chip select is discarded.
module flash_cmd_core #(
  parameter logic [7:0] MAKER_ID = 8'h11,  // arbitrary value
  parameter logic [7:0] MEMORY_TYPE = 8'h22,  // arbitrary value
  parameter logic [7:0] MEMORY_DENSITY = 8'h33,  // arbitrary value
  parameter logic [7:0] SIGNATURE_ID = 8'h33,  // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h44,  // arbitrary value
  parameter logic [7:0] PAGE_WRITE_CMD = 8'h02,
  parameter logic [7:0] QUAD_PAGE_WRITE_CMD = 8'h38
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link pins
  input wire logic hw_reset_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o,
  // Configuration and status
  input wire logic quad_command_mode_i,
  input wire logic [5:0] status_upper_i,
  output logic write_enable_latch_o,
  output logic factory_mode_o,
  // Operation engine
  input wire logic write_in_progress_i,
  input wire logic op_done_i,
  input wire logic op_done_write_erase_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic soft_reset_o
);

  // ----------------------------------------------------------------
  // Pin sampling and edges
  // ----------------------------------------------------------------
  flash_cmd_pkg::link_pins_type pins_s;
  flash_cmd_pkg::frame_state_type state_q;
  flash_cmd_pkg::read_kind_type kind_q;
  flash_cmd_pkg::read_kind_type kind_d;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic rise;
  logic fall;
  logic cs_high;
  logic cs_up;
  logic hw_reset;
  logic quad;
  logic [4:0] step;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic opc_done;
  logic pend_q;
  logic [7:0] pend_op_q;
  logic exec;
  logic arm_q;
  logic wel_q;
  logic fm_q;
  logic addr_odd_q;
  logic [1:0] idx_q;
  logic [7:0] out_byte;
  logic [7:0] status_byte;
  logic shift_empty;
  logic is_pe;
  logic is_susp;
  logic is_local;

  flash_pin_sync #(
    .WIDTH(7),
    .IDLE_VALUE(flash_cmd_pkg::PINS_IDLE)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pins_i({hw_reset_n_i, cs_n_i, sclk_i, sio_i}),
    .pins_o(pins_s)
  );

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= pins_s.sclk;
      cs_prev_q <= pins_s.cs_n;
    end
  end

  assign rise = pins_s.sclk && !sclk_prev_q;
  assign fall = !pins_s.sclk && sclk_prev_q;
  assign cs_high = pins_s.cs_n;
  assign cs_up = cs_high && !cs_prev_q;
  assign hw_reset = !pins_s.hw_reset_n;
  assign quad = quad_command_mode_i;
  assign step = quad ? flash_cmd_pkg::QUAD_STEP : flash_cmd_pkg::SINGLE_STEP;
  assign cnt_d = cnt_q + step;
  assign rx_d = quad ? {rx_q[3:0], pins_s.sio} : {rx_q[6:0], pins_s.sio[0]}; // R5
  assign opc_done = (state_q == flash_cmd_pkg::ST_OPCODE) && !cs_high &&
                    rise && (cnt_d == flash_cmd_pkg::OPCODE_BITS); // R5 R22
  assign exec = cs_up && pend_q;

  // ----------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------
  assign is_pe = (rx_d == PAGE_WRITE_CMD) || (rx_d == QUAD_PAGE_WRITE_CMD) ||
                 (rx_d == flash_cmd_pkg::SMALL_UNIT_WIPE_CMD) ||
                 (rx_d == flash_cmd_pkg::HALF_BLOCK_WIPE_CMD) ||
                 (rx_d == flash_cmd_pkg::BLOCK_WIPE_CMD) ||
                 (rx_d == flash_cmd_pkg::DEVICE_WIPE_CMD_A) ||
                 (rx_d == flash_cmd_pkg::DEVICE_WIPE_CMD_B);
  assign is_susp = (rx_d == flash_cmd_pkg::SUSPEND_CMD_A) ||
                   (rx_d == flash_cmd_pkg::SUSPEND_CMD_B);
  assign is_local = (rx_d == flash_cmd_pkg::LATCH_SET_CMD) ||
                    (rx_d == flash_cmd_pkg::LATCH_CLEAR_CMD) ||
                    (rx_d == flash_cmd_pkg::FACTORY_SPEEDUP_CMD) ||
                    (rx_d == flash_cmd_pkg::RESET_ARM_CMD) ||
                    (rx_d == flash_cmd_pkg::RESET_MEMORY_CMD) ||
                    (rx_d == flash_cmd_pkg::THREE_BYTE_ID_CMD) ||
                    (rx_d == flash_cmd_pkg::MAKER_DEVICE_ID_CMD) ||
                    (rx_d == flash_cmd_pkg::QUAD_ID_CMD) ||
                    (kind_d != flash_cmd_pkg::RD_NONE); // R12

  always_comb
  begin
    kind_d = flash_cmd_pkg::RD_NONE;
    case (rx_d)
      flash_cmd_pkg::THREE_BYTE_ID_CMD:
        if (!quad && !write_in_progress_i) kind_d = flash_cmd_pkg::RD_ID3; // R11 R12
      flash_cmd_pkg::LEGACY_SIGNATURE_CMD: kind_d = flash_cmd_pkg::RD_SIG; // R14
      flash_cmd_pkg::MAKER_DEVICE_ID_CMD:
        if (!quad) kind_d = flash_cmd_pkg::RD_PAIR; // R15
      flash_cmd_pkg::QUAD_ID_CMD:
        if (quad) kind_d = flash_cmd_pkg::RD_QID; // R17
      flash_cmd_pkg::READ_STATUS_CMD: kind_d = flash_cmd_pkg::RD_STATUS; // R18
      default: kind_d = flash_cmd_pkg::RD_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || cs_high)
    begin
      state_q <= flash_cmd_pkg::ST_OPCODE; // R13 R22
      cnt_q <= 5'd0;
      rx_q <= 8'h00;
      kind_q <= flash_cmd_pkg::RD_NONE;
    end
    else if (rise)
    begin
      case (state_q)
        flash_cmd_pkg::ST_OPCODE:
        begin
          rx_q <= rx_d;
          cnt_q <= opc_done ? 5'd0 : cnt_d;
          if (opc_done)
          begin
            kind_q <= kind_d;
            if (kind_d == flash_cmd_pkg::RD_NONE)
              state_q <= flash_cmd_pkg::ST_HOLD;
            else if (kind_d == flash_cmd_pkg::RD_SIG ||
                     kind_d == flash_cmd_pkg::RD_PAIR)
              state_q <= flash_cmd_pkg::ST_PREAMBLE; // R14 R15
            else
              state_q <= flash_cmd_pkg::ST_DATA; // R17
          end
        end
        flash_cmd_pkg::ST_PREAMBLE:
        begin
          rx_q <= rx_d;
          cnt_q <= cnt_d;
          if (cnt_d == flash_cmd_pkg::PREAMBLE_BITS)
            state_q <= flash_cmd_pkg::ST_DATA;
        end
        flash_cmd_pkg::ST_DATA: state_q <= flash_cmd_pkg::ST_DATA;
        flash_cmd_pkg::ST_HOLD: state_q <= flash_cmd_pkg::ST_HOLD;
        default: state_q <= flash_cmd_pkg::ST_HOLD;
      endcase
    end
  end

  // Address byte of the maker/device read
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      addr_odd_q <= 1'b0;
    else if (rise && state_q == flash_cmd_pkg::ST_PREAMBLE &&
             cnt_d == flash_cmd_pkg::PREAMBLE_BITS)
      addr_odd_q <= rx_d[0]; // R16
  end

  // Opcode held for execution at chip select release
  always_ff @(posedge clk_i)
  begin
    if (reset_i || cs_up)
    begin
      pend_q <= 1'b0;
      pend_op_q <= 8'h00;
    end
    else if (opc_done)
    begin
      pend_q <= 1'b1;
      pend_op_q <= rx_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset pairing, latch and factory mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i || hw_reset)
    begin
      arm_q <= 1'b0;
      soft_reset_o <= 1'b0;
    end
    else
    begin
      soft_reset_o <= exec && arm_q &&
                      pend_op_q == flash_cmd_pkg::RESET_MEMORY_CMD; // R1
      if (exec && pend_op_q == flash_cmd_pkg::RESET_ARM_CMD)
        arm_q <= 1'b1;
      else if (exec || (opc_done && rx_d != flash_cmd_pkg::RESET_MEMORY_CMD))
        arm_q <= 1'b0; // R1
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || hw_reset)
      wel_q <= 1'b0; // R7
    else if (exec && pend_op_q == flash_cmd_pkg::LATCH_SET_CMD)
      wel_q <= 1'b1; // R3
    else if ((exec && pend_op_q == flash_cmd_pkg::LATCH_CLEAR_CMD) ||
             soft_reset_o || op_done_i)
      wel_q <= 1'b0; // R6 R7
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || hw_reset)
      fm_q <= 1'b0; // R10
    else if (exec && pend_op_q == flash_cmd_pkg::FACTORY_SPEEDUP_CMD)
      fm_q <= 1'b1;
    else if (soft_reset_o || (op_done_i && op_done_write_erase_i))
      fm_q <= 1'b0; // R10
  end

  assign write_enable_latch_o = wel_q;
  assign factory_mode_o = fm_q;

  // ----------------------------------------------------------------
  // Command forwarding to the operation engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
    end
    else
    begin
      cmd_valid_o <= opc_done && !is_local && !(is_pe && !wel_q) &&
                     !(is_susp && fm_q); // R9 R20
      if (opc_done)
        cmd_code_o <= rx_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  assign status_byte = {status_upper_i, wel_q, write_in_progress_i}; // R21

  always_comb
  begin
    case (kind_q)
      flash_cmd_pkg::RD_ID3, flash_cmd_pkg::RD_QID:
        out_byte = (idx_q == 2'd0) ? MAKER_ID :
                   (idx_q == 2'd1) ? MEMORY_TYPE : MEMORY_DENSITY; // R11 R17
      flash_cmd_pkg::RD_SIG: out_byte = SIGNATURE_ID; // R14
      flash_cmd_pkg::RD_PAIR:
        out_byte = (idx_q[0] ^ addr_odd_q) ? DEVICE_ID : MAKER_ID; // R16
      flash_cmd_pkg::RD_STATUS: out_byte = status_byte; // R18
      default: out_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i || cs_high)
      idx_q <= 2'd0;
    else if (fall && state_q == flash_cmd_pkg::ST_DATA && shift_empty)
      idx_q <= (idx_q == flash_cmd_pkg::ID_BYTES_LAST ||
                (kind_q == flash_cmd_pkg::RD_PAIR && idx_q == 2'd1)) ?
               2'd0 : idx_q + 2'd1; // R16
  end

  flash_out_shift u_shift (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(cs_high),
    .step_i(fall && state_q == flash_cmd_pkg::ST_DATA),
    .quad_i(quad),
    .byte_i(out_byte),
    .lanes_o(sio_o),
    .empty_o(shift_empty)
  );

  always_ff @(posedge clk_i)
  begin
    if (reset_i || cs_high)
      sio_oe_o <= 4'h0; // R13
    else if (fall && state_q == flash_cmd_pkg::ST_DATA)
      sio_oe_o <= quad ? flash_cmd_pkg::QPI_OUT_ENABLE :
                         flash_cmd_pkg::SPI_OUT_ENABLE; // R15
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_cs_up;
    cs_high && !cs_prev_q;
  endsequence

  sequence s_exec_op(logic [7:0] op);
    s_cs_up ##0 pend_q && pend_op_q == op && !hw_reset;
  endsequence

  chk_latch_set: assert property (s_exec_op(flash_cmd_pkg::LATCH_SET_CMD)
    |=> wel_q) else $error("latch not set"); // R3
  chk_latch_clear: assert property (s_exec_op(flash_cmd_pkg::LATCH_CLEAR_CMD)
    |=> !wel_q) else $error("latch not cleared"); // R6
  chk_latch_done: assert property (op_done_i && !exec
    |=> !wel_q) else $error("latch kept after completion"); // R7
  chk_factory_done: assert property (op_done_i && op_done_write_erase_i &&
    !exec |=> !fm_q) else $error("factory mode kept"); // R10
  chk_suspend_block: assert property (opc_done && is_susp && fm_q
    |=> !cmd_valid_o) else $error("suspend passed in factory mode"); // R9
  chk_pe_gate: assert property (opc_done && is_pe && !wel_q
    |=> !cmd_valid_o) else $error("program passed without latch"); // R20
  chk_reset_pair: assert property (soft_reset_o |-> $past(arm_q) &&
    $past(pend_op_q) == flash_cmd_pkg::RESET_MEMORY_CMD)
    else $error("memory reset without arm"); // R1
  chk_id_busy: assert property (opc_done && write_in_progress_i &&
    rx_d == flash_cmd_pkg::THREE_BYTE_ID_CMD |=> kind_q == flash_cmd_pkg::RD_NONE)
    else $error("id read decoded while busy"); // R12
  chk_id_not_fwd: assert property (opc_done &&
    rx_d == flash_cmd_pkg::THREE_BYTE_ID_CMD |=> !cmd_valid_o) // R12
    else $error("id read forwarded to engine");
  chk_standby_oe: assert property (s_cs_up |=> sio_oe_o == 4'h0 [*2])
    else $error("output left on after deselect"); // R13
  chk_partial_drop: assert property (s_cs_up ##0 !pend_q |=> !soft_reset_o &&
    $stable(wel_q) || op_done_i) else $error("partial opcode acted"); // R22
  chk_opcode_len: assert property (opc_done |-> cnt_q == (quad ? 5'd4 : 5'd7))
    else $error("opcode length wrong"); // R5

endmodule : flash_cmd_core

/* File: tb/flash_host_model.sv */
// Host controller model driving the flash command pins
`timescale 1ns/1ps
module flash_host_model (
  // Clock
  input wire logic clk_i,
  // Lane mode
  input wire logic quad_i,
  // Device answer
  input wire logic [3:0] dev_sio_i,
  input wire logic [3:0] dev_oe_i,
  // Link pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] sio_o
);
  logic [3:0] oe_seen;

  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sio_o = 4'h0;
    oe_seen = 4'h0;
  end

  // ----------------------------------------------------------------
  // Link clock: four cycles low, four high
  // ----------------------------------------------------------------
  task automatic pulse();
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : pulse

  // ----------------------------------------------------------------
  // Frame: input bits MSB first, then read bits, then deselect
  // ----------------------------------------------------------------
  task automatic frame(input logic [31:0] word, input int n_in,
    input int n_rd, output logic [31:0] rd);
    logic [31:0] w;
    int step;
    w = word;
    rd = 32'h0;
    step = quad_i ? 4 : 1;
    oe_seen = 4'h0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n_in; i += step)
    begin
      sclk_o <= 1'b0;
      sio_o <= quad_i ? w[31:28] : {~sio_o[3:1], w[31]};
      w = w << step;
      pulse();
    end
    for (int i = 0; i < n_rd; i += step)
    begin
      sclk_o <= 1'b0;
      sio_o <= ~sio_o;
      pulse();
      oe_seen = oe_seen | dev_oe_i;
      rd = quad_i ? {rd[27:0], dev_sio_i} : {rd[30:0], dev_sio_i[1]};
    end
    sclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (12) @(posedge clk_i);
  endtask : frame
endmodule : flash_host_model

/* File: tb/serial_flash_enable_id_status_cmds_tb_top.sv */
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module serial_flash_enable_id_status_cmds_tb_top;
  localparam logic [7:0] MK = 8'h11;
  localparam logic [7:0] TY = 8'h22;
  localparam logic [7:0] DN = 8'h33;
  localparam logic [7:0] SG = 8'h5A;
  localparam logic [7:0] DV = 8'h44;
  localparam logic [7:0] PW = 8'h02;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hw_reset_n = 1'b1;
  logic quad = 1'b0;
  logic [5:0] status_upper = 6'h00;
  logic write_in_progress = 1'b0;
  logic op_done = 1'b0;
  logic op_we = 1'b0;
  logic cs_n;
  logic sclk;
  logic [3:0] host_sio;
  logic [3:0] dev_sio;
  logic [3:0] dev_oe;
  logic [3:0] sio_w;
  logic write_enable_latch;
  logic fmode;
  logic cmd_valid;
  logic soft_reset;
  logic [7:0] cmd_code;
  logic [7:0] st;
  logic [31:0] rd_v;
  logic [31:0] seed = 32'h3D6782BF;
  int n_mismatch = 0;
  int checked = 0;
  int n_fwd = 0;
  int n_soft = 0;
  int wel_m = 0;
  int fm_m = 0;
  int fwd_m = 0;
  int soft_m = 0;

  always #5 clk_i = ~clk_i;
  assign sio_w = (dev_oe & dev_sio) | (~dev_oe & host_sio);

  flash_cmd_core #(.MAKER_ID(MK), .MEMORY_TYPE(TY), .MEMORY_DENSITY(DN),
    .SIGNATURE_ID(SG), .DEVICE_ID(DV), .PAGE_WRITE_CMD(PW)) i_flash_cmd_core (
    .clk_i(clk_i), .reset_i(reset_i), .hw_reset_n_i(hw_reset_n),
    .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(sio_w), .sio_o(dev_sio),
    .sio_oe_o(dev_oe), .quad_command_mode_i(quad),
    .status_upper_i(status_upper), .write_enable_latch_o(write_enable_latch),
    .factory_mode_o(fmode), .write_in_progress_i(write_in_progress),
    .op_done_i(op_done), .op_done_write_erase_i(op_we),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
    .soft_reset_o(soft_reset));

  flash_host_model i_flash_host_model (.clk_i(clk_i), .quad_i(quad),
    .dev_sio_i(dev_sio), .dev_oe_i(dev_oe), .cs_n_o(cs_n),
    .sclk_o(sclk), .sio_o(host_sio));

  // ----------------------------------------------------------------
  // Pulse counters
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (cmd_valid === 1'b1) n_fwd <= n_fwd + 1;
    if (soft_reset === 1'b1) n_soft <= n_soft + 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic frame(input logic [31:0] w, input int n_in, input int n);
    i_flash_host_model.frame(w, n_in, n, rd_v);
    seed = xorshift(seed);
  endtask : frame

  task automatic cmd(input logic [7:0] op);
    frame({op, 24'h0}, 8, 0);
  endtask : cmd

  task automatic set_mode(input logic q);
    quad <= q;
    @(posedge clk_i);
  endtask : set_mode

  task automatic levels();
    check("latch", wel_m, {31'h0, write_enable_latch});
    check("factory", fm_m, {31'h0, fmode});
    check("fwd", fwd_m, n_fwd);
    check("soft", soft_m, n_soft);
  endtask : levels

  task automatic done(input logic we);
    op_we <= we;
    op_done <= 1'b1;
    @(posedge clk_i);
    op_done <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : done

  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    #500000;
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    levels();
    for (int q = 0; q < 2; q++)
    begin
      set_mode(q[0]);
      cmd(flash_cmd_pkg::LATCH_SET_CMD);
      wel_m = 1;
      levels();
      cmd(flash_cmd_pkg::LATCH_CLEAR_CMD);
      wel_m = 0;
      levels();
    end
    set_mode(1'b0);
    frame({flash_cmd_pkg::LATCH_SET_CMD, 24'h0}, 4, 0);
    levels();
    cmd(PW);
    levels();
    cmd(flash_cmd_pkg::LATCH_SET_CMD);
    cmd(PW);
    wel_m = 1;
    fwd_m++;
    levels();
    check("code", {24'h0, PW}, {24'h0, cmd_code});
    done(1'b1);
    wel_m = 0;
    levels();
    cmd(flash_cmd_pkg::LATCH_SET_CMD);
    cmd(flash_cmd_pkg::FACTORY_SPEEDUP_CMD);
    wel_m = 1;
    fm_m = 1;
    levels();
    cmd(flash_cmd_pkg::SUSPEND_CMD_A);
    cmd(flash_cmd_pkg::SUSPEND_CMD_B);
    levels();
    cmd(flash_cmd_pkg::SMALL_UNIT_WIPE_CMD);
    fwd_m++;
    done(1'b1);
    wel_m = 0;
    fm_m = 0;
    levels();
    cmd(flash_cmd_pkg::LATCH_SET_CMD);
    cmd(flash_cmd_pkg::FACTORY_SPEEDUP_CMD);
    done(1'b0);
    fm_m = 1;
    levels();
    cmd(flash_cmd_pkg::RESET_ARM_CMD);
    frame({flash_cmd_pkg::READ_STATUS_CMD, 24'h0}, 8, 8);
    cmd(flash_cmd_pkg::RESET_MEMORY_CMD);
    levels();
    cmd(flash_cmd_pkg::LATCH_SET_CMD);
    cmd(flash_cmd_pkg::RESET_ARM_CMD);
    cmd(flash_cmd_pkg::RESET_MEMORY_CMD);
    soft_m++;
    fm_m = 0;
    levels();
    frame({flash_cmd_pkg::THREE_BYTE_ID_CMD, 24'h0}, 8, 24);
    check("id3", {8'h0, MK, TY, DN}, rd_v);
    check("oe", 0, {28'h0, dev_oe});
    cmd(flash_cmd_pkg::LATCH_SET_CMD);
    wel_m = 1;
    write_in_progress <= 1'b1;
    frame({flash_cmd_pkg::THREE_BYTE_ID_CMD, 24'h0}, 8, 24);
    check("busy id", 0, {28'h0, i_flash_host_model.oe_seen});
    for (int q = 0; q < 2; q++)
    begin
      set_mode(q[0]);
      status_upper <= seed[5:0];
      frame({flash_cmd_pkg::READ_STATUS_CMD, 24'h0}, 8, 16);
      st = {status_upper, 1'b1, 1'b1};
      check("status", {16'h0, st, st}, rd_v);
    end
    write_in_progress <= 1'b0;
    frame({flash_cmd_pkg::THREE_BYTE_ID_CMD, 24'h0}, 8, 24);
    check("quad id3", 0, {28'h0, i_flash_host_model.oe_seen});
    frame({flash_cmd_pkg::MAKER_DEVICE_ID_CMD, 24'h0}, 32, 16);
    check("quad pair", 0, {28'h0, i_flash_host_model.oe_seen});
    frame({flash_cmd_pkg::QUAD_ID_CMD, 24'h0}, 8, 32);
    check("qid", {MK, TY, DN, MK}, rd_v);
    for (int q = 0; q < 2; q++)
    begin
      set_mode(q[0] ^ 1'b1);
      frame({flash_cmd_pkg::LEGACY_SIGNATURE_CMD, seed[23:0]}, 32, 16);
      check("sig", {16'h0, SG, SG}, rd_v);
    end
    for (int a = 0; a < 2; a++)
    begin
      frame({flash_cmd_pkg::MAKER_DEVICE_ID_CMD, seed[15:0], 7'h0, a[0]},
        32, 32);
      check("pair", a[0] ? {DV, MK, DV, MK} : {MK, DV, MK, DV}, rd_v);
    end
    check("pair oe", 32'h2, {28'h0, i_flash_host_model.oe_seen});
    cmd(flash_cmd_pkg::FACTORY_SPEEDUP_CMD);
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    hw_reset_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    wel_m = 0;
    levels();
    give_verdict();
  end
endmodule : serial_flash_enable_id_status_cmds_tb_top
